// [pcg_pads.sv]
// External circuitry on the eight multi-function pins
`timescale 1ns/1ps

module pcg_pads (
	// Pin side of the block
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	// Outside level, changed by the bench so a released pin never keeps a stale value
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pin_in
);
	// No pulls: an undriven pin shows only what the outside puts on it
	assign pin_in = (pin_out & pin_oe) | (ext_val & ~pin_oe);
endmodule : pcg_pads

// [pcg_pin_config.sv]
// Pin configuration block: general-purpose I/O, debug output selector and pad speed
`timescale 1ns/1ps
`include "pcg_regs.svh"

module pcg_pin_config #(
	parameter int NUM_PINS = 8
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	// Register port from the host interface
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [7:0]            reg_addr,
	input  wire pcg_pkg::pcg_byte_t    reg_wdata,
	output pcg_pkg::pcg_byte_t         reg_rdata,
	output logic                       reg_hit,
	// Configuration from elsewhere in the device
	input  wire logic                  boundary_scan_active,
	input  wire logic [3:0]            clock_pin_source_code,
	input  wire logic                  clock_function_out,
	// Internal status signals for the debug pin
	input  wire logic                  tx_envelope,
	input  wire logic                  tx_active,
	input  wire logic                  generic_serial_carrier,
	input  wire logic                  rx_envelope,
	input  wire logic                  rx_active,
	input  wire logic                  rx_bit,
	// Multi-function pins, bit 7 signal-in .. bit 0 scan
	input  wire logic [NUM_PINS-1:0]   pin_in,
	output logic      [NUM_PINS-1:0]   pin_out,
	output logic      [NUM_PINS-1:0]   pin_oe,
	output logic                       clock_pin_gpio,
	output logic                       fast_edge_select,
	// Debug output pin
	output logic                       debug_output_pin,
	output logic                       debug_output_pin_oe
);

	import pcg_pkg::*;

	typedef struct packed {
		pcg_byte_t pin_output_enable;
		pcg_byte_t pin_output_value;
		pcg_byte_t debug_signal_select;
		pcg_byte_t rdata;
		logic      hit;
		logic      dbg_val;
		logic      dbg_oe;
		logic [NUM_PINS-1:0] pout;
		logic [NUM_PINS-1:0] poe;
		logic      clk_gpio;
	} pcg_state_s;

	pcg_state_s state_ff;
	pcg_state_s nxt_state;

	logic [NUM_PINS-1:0] pin_level;

	// ==========================================================
	// Pin input synchronisation: pins come from outside the clock domain
	pcg_pin_sync #(
		.WIDTH     (NUM_PINS)
	) u_sync (
		.clk       (clk),
		.rst_b     (rst_b),
		.pin_raw   (pin_in),
		.pin_level (pin_level)
	);

	// Address decode shared by read and write paths
	function automatic logic pcg_is_mapped(input logic [7:0] a);
		return (a == `PCG_ADDR_PIN_OUTPUT_ENABLE) || (a == `PCG_ADDR_PIN_OUTPUT_VALUE) ||
		       (a == `PCG_ADDR_PIN_INPUT_LEVEL) || (a == `PCG_ADDR_DEBUG_SIGNAL_SELECT);
	endfunction : pcg_is_mapped

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic [NUM_PINS-1:0] eff_en;
		logic                clk_io;
		pcg_debug_code_e     code;
		eff_en    = '0;
		clk_io    = 1'b0;
		code      = PCG_DBG_OFF0;
		nxt_state = state_ff;

		// Register writes; the input level register has no storage
		if (reg_wr) begin
			unique case (reg_addr)
				`PCG_ADDR_PIN_OUTPUT_ENABLE:   nxt_state.pin_output_enable = reg_wdata;
				`PCG_ADDR_PIN_OUTPUT_VALUE:    nxt_state.pin_output_value  = reg_wdata;
				`PCG_ADDR_DEBUG_SIGNAL_SELECT: begin
					nxt_state.debug_signal_select = reg_wdata & `PCG_DEBUG_SELECT_MASK;
				end
				default: ;
			endcase
		end

		// Register reads, registered so data is stable one cycle later
		nxt_state.hit   = (reg_rd || reg_wr) && pcg_is_mapped(reg_addr);
		nxt_state.rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				`PCG_ADDR_PIN_OUTPUT_ENABLE:   nxt_state.rdata = state_ff.pin_output_enable;
				`PCG_ADDR_PIN_OUTPUT_VALUE:    nxt_state.rdata = state_ff.pin_output_value;
				`PCG_ADDR_PIN_INPUT_LEVEL:     nxt_state.rdata = pin_level;
				`PCG_ADDR_DEBUG_SIGNAL_SELECT: nxt_state.rdata = state_ff.debug_signal_select;
				default:                       nxt_state.rdata = 8'h00;
			endcase
		end

		// Effective enables: scan pins stay with the scan logic when it owns them
		eff_en = state_ff.pin_output_enable;
		if (boundary_scan_active) begin
			eff_en = eff_en & ~`PCG_SCAN_PIN_MASK;
		end

		// Clock pin is plain I/O when its enable is set or no clock source is chosen
		clk_io = eff_en[`PCG_BIT_CLOCK_OUTPUT_PIN] || (clock_pin_source_code == 4'h0);
		nxt_state.clk_gpio = clk_io;

		// Pad drivers
		nxt_state.poe  = eff_en;
		nxt_state.pout = state_ff.pin_output_value;
		if (!clk_io) begin
			// Clock function keeps the pin: drive the generated clock level
			nxt_state.poe[`PCG_BIT_CLOCK_OUTPUT_PIN]  = 1'b1;
			nxt_state.pout[`PCG_BIT_CLOCK_OUTPUT_PIN] = clock_function_out;
		end

		// Debug pin source; unknown codes float the pin
		nxt_state.dbg_oe  = 1'b1;
		nxt_state.dbg_val = 1'b0;
		if (state_ff.debug_signal_select[3:0] > 4'h9) begin
			nxt_state.dbg_oe = 1'b0;
		end else begin
			code = pcg_debug_code_e'(state_ff.debug_signal_select[3:0]);
			unique case (code)
				PCG_DBG_OFF0, PCG_DBG_OFF1: nxt_state.dbg_oe = 1'b0;
				PCG_DBG_LOW:     nxt_state.dbg_val = 1'b0;
				PCG_DBG_HIGH:    nxt_state.dbg_val = 1'b1;
				PCG_DBG_TX_ENV:  nxt_state.dbg_val = tx_envelope;
				PCG_DBG_TX_ACT:  nxt_state.dbg_val = tx_active;
				PCG_DBG_CARRIER: nxt_state.dbg_val = generic_serial_carrier;
				PCG_DBG_RX_ENV:  nxt_state.dbg_val = rx_envelope;
				PCG_DBG_RX_ACT:  nxt_state.dbg_val = rx_active;
				PCG_DBG_RX_BIT:  nxt_state.dbg_val = rx_bit;
			endcase
		end
	end

	// ==========================================================
	// State register; all pins released during reset
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_ff                     <= '0;
			state_ff.pin_output_enable   <= `PCG_RST_PIN_OUTPUT_ENABLE;
			state_ff.pin_output_value    <= `PCG_RST_PIN_OUTPUT_VALUE;
			state_ff.debug_signal_select <= `PCG_RST_DEBUG_SIGNAL_SELECT;
			state_ff.rdata               <= `PCG_RST_PIN_INPUT_LEVEL;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ==========================================================
	// Outputs, all from flip-flops
	assign reg_rdata           = state_ff.rdata;
	assign reg_hit             = state_ff.hit;
	assign pin_out             = state_ff.pout;
	assign pin_oe              = state_ff.poe;
	assign clock_pin_gpio      = state_ff.clk_gpio;
	assign fast_edge_select    = state_ff.debug_signal_select[`PCG_BIT_FAST_EDGE];
	assign debug_output_pin    = state_ff.dbg_val;
	assign debug_output_pin_oe = state_ff.dbg_oe;

endmodule : pcg_pin_config

// [pcg_pin_config_chk.sv]
// Concurrent checks on the ports of the pin configuration block
`timescale 1ns/1ps

module pcg_pin_config_chk
	import pcg_pkg::*;
#(
	parameter int NUM_PINS = 8
) (
	// Clock, reset and register port
	input wire logic                clk, rst_b, reg_wr, reg_rd, reg_hit,
	input wire logic [7:0]          reg_addr,
	input wire pcg_pkg::pcg_byte_t  reg_wdata, reg_rdata,
	// Device configuration and status sources
	input wire logic                boundary_scan_active, clock_function_out,
	input wire logic [3:0]          clock_pin_source_code,
	input wire logic                tx_envelope, tx_active, generic_serial_carrier,
	input wire logic                rx_envelope, rx_active, rx_bit,
	// Pins
	input wire logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe,
	input wire logic                clock_pin_gpio, fast_edge_select,
	input wire logic                debug_output_pin, debug_output_pin_oe
);
	typedef struct packed {pcg_byte_t en; pcg_byte_t val; pcg_byte_t sel;} pcg_shadow_s;
	pcg_shadow_s sh_ff, nxt_sh;
	logic [9:0]  dbg_src;

	// ==========================================================
	// Shadow of the writable registers, reserved bits dropped on write
	always_comb begin
		nxt_sh = sh_ff;
		if (reg_wr && reg_addr == 8'h44) nxt_sh.en = reg_wdata;
		if (reg_wr && reg_addr == 8'h45) nxt_sh.val = reg_wdata;
		if (reg_wr && reg_addr == 8'h47) nxt_sh.sel = reg_wdata & 8'h8f;
	end
	always_ff @(posedge clk) sh_ff <= rst_b ? nxt_sh : '0;
	// Source per code; entries 2 and 3 stand for the constant levels
	assign dbg_src = {rx_bit, rx_active, rx_envelope, generic_serial_carrier,
		tx_active, tx_envelope, 4'h8};

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// ==========================================================
	// Checks
	oe_map_a: assert property (
		1'b1 |=> {pin_oe[7], pin_oe[5:4]} == $past({sh_ff.en[7], sh_ff.en[5:4]}))
		else $error("pin enable does not follow its register");
	scan_mask_a: assert property (
		1'b1 |=> pin_oe[3:0] == ($past(boundary_scan_active) ? 4'h0 : $past(sh_ff.en[3:0])))
		else $error("scan pin enable wrong");
	out_map_a: assert property (
		1'b1 |=> ((pin_out ^ $past(sh_ff.val)) & pin_oe & 8'hbf) == 8'h00)
		else $error("driven pin value wrong");
	clk_gpio_a: assert property (
		(sh_ff.en[6] || clock_pin_source_code == 4'h0)
		|=> clock_pin_gpio && pin_oe[6] == $past(sh_ff.en[6])) else $error("clock pin not I/O");
	clk_func_a: assert property (
		!(sh_ff.en[6] || clock_pin_source_code == 4'h0) |=> !clock_pin_gpio && pin_oe[6]
		&& pin_out[6] == $past(clock_function_out)) else $error("clock pin function lost");
	rd_sel_a: assert property (
		reg_rd && !reg_wr && reg_addr == 8'h47 |=> reg_rdata == $past(sh_ff.sel))
		else $error("select register read wrong");
	hit_a: assert property (
		(reg_rd || reg_wr) |=> reg_hit == $past(reg_addr[7:2] == 6'h11))
		else $error("address decode wrong");
	idle_a: assert property (
		!(reg_rd || reg_wr) |=> !reg_hit && reg_rdata == 8'h00) else $error("idle bus not quiet");
	fast_edge_a: assert property (
		$stable(sh_ff.sel[7]) |-> fast_edge_select == sh_ff.sel[7]) else $error("pad speed wrong");
	dbg_src_a: assert property (
		sh_ff.sel[3:0] inside {[4'h2:4'h9]} |=> debug_output_pin_oe
		&& debug_output_pin == $past(dbg_src[sh_ff.sel[3:0]])) else $error("debug pin wrong");
	dbg_float_a: assert property (
		!(sh_ff.sel[3:0] inside {[4'h2:4'h9]}) |=> !debug_output_pin_oe)
		else $error("debug pin not floating");
endmodule : pcg_pin_config_chk

bind pcg_pin_config pcg_pin_config_chk #(.NUM_PINS(NUM_PINS)) u_chk (.*);

// [pcg_pin_sync.sv]
// Three-stage input synchroniser with agreement filter for the eight pins
`timescale 1ns/1ps

module pcg_pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	// Pin levels and filtered result
	input  wire logic [WIDTH-1:0] pin_raw,
	output logic      [WIDTH-1:0] pin_level
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] lvl;
	} pcg_sync_s;

	pcg_sync_s state_ff;
	pcg_sync_s nxt_state;

	// ==========================================================
	// Shift chain; a bit changes only once stages two and three agree
	always_comb begin
		nxt_state     = state_ff;
		nxt_state.s1  = pin_raw;
		nxt_state.s2  = state_ff.s1;
		nxt_state.s3  = state_ff.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (state_ff.s2[i] == state_ff.s3[i]) begin
				nxt_state.lvl[i] = state_ff.s3[i];
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign pin_level = state_ff.lvl;

endmodule : pcg_pin_sync

// [pcg_pkg.sv]
// Types shared by the pin configuration block
package pcg_pkg;

	// ==========================================================
	// Debug output source codes
	typedef enum logic [3:0] {
		PCG_DBG_OFF0     = 4'h0,
		PCG_DBG_OFF1     = 4'h1,
		PCG_DBG_LOW      = 4'h2,
		PCG_DBG_HIGH     = 4'h3,
		PCG_DBG_TX_ENV   = 4'h4,
		PCG_DBG_TX_ACT   = 4'h5,
		PCG_DBG_CARRIER  = 4'h6,
		PCG_DBG_RX_ENV   = 4'h7,
		PCG_DBG_RX_ACT   = 4'h8,
		PCG_DBG_RX_BIT   = 4'h9
	} pcg_debug_code_e;

	typedef logic [7:0] pcg_byte_t;

endpackage : pcg_pkg

// [pcg_regs.svh]
// Register offsets, field positions and reset values of the pin configuration block
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH

// ==========================================================
// Register offsets
`define PCG_ADDR_PIN_OUTPUT_ENABLE   8'h44
`define PCG_ADDR_PIN_OUTPUT_VALUE    8'h45
`define PCG_ADDR_PIN_INPUT_LEVEL     8'h46
`define PCG_ADDR_DEBUG_SIGNAL_SELECT 8'h47

// ==========================================================
// Field positions
`define PCG_BIT_SIGNAL_INPUT_PIN     3'd7
`define PCG_BIT_CLOCK_OUTPUT_PIN     3'd6
`define PCG_SCAN_PIN_MASK            8'h0f
`define PCG_BIT_FAST_EDGE            3'd7
`define PCG_DEBUG_SELECT_MASK        8'h8f

// ==========================================================
// Reset values
`define PCG_RST_PIN_OUTPUT_ENABLE    8'h00
`define PCG_RST_PIN_OUTPUT_VALUE     8'h00
`define PCG_RST_DEBUG_SIGNAL_SELECT  8'h00
`define PCG_RST_PIN_INPUT_LEVEL      8'h00

`endif

// [tb_top.sv]
// Self-checking bench for the pin configuration block
`timescale 1ns/1ps

module tb_top;
	import pcg_pkg::*;
	logic       clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_hit;
	logic       boundary_scan_active = 1'b0, clock_function_out = 1'b0;
	logic [7:0] reg_addr = 8'h00, pin_in, pin_out, pin_oe;
	pcg_byte_t  reg_wdata = 8'h00, reg_rdata, ext_val = 8'h00, en, val, sel, eo, ev;
	logic [3:0] clock_pin_source_code = 4'h0;
	logic [5:0] src = 6'h00;
	logic       tx_envelope, tx_active, generic_serial_carrier, rx_envelope, rx_active, rx_bit;
	logic       clock_pin_gpio, fast_edge_select, debug_output_pin, debug_output_pin_oe;
	int         n_mismatch = 0, total_checks = 0, seed = 53591;

	assign {rx_bit, rx_active, rx_envelope, generic_serial_carrier, tx_active, tx_envelope} = src;
	always #5 clk = ~clk;
	pcg_pin_config uut (.*);
	pcg_pads       pads (.*);

	// ==========================================================
	// Bus cycles and comparison
	task op(input logic w, r, input logic [7:0] a, d);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask : op
	task chk(input logic [7:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One strobe, then the answer is sampled in the single cycle it stands
	task xfer(input logic w, r, input logic [7:0] a, d, exp, input logic hit);
		op(w, r, a, d);
		op(1'b0, 1'b0, a, d);
		#1;
		chk(reg_rdata, exp);
		chk({7'h00, reg_hit}, {7'h00, hit});
	endtask : xfer
	// Expected debug pin as {enable, value}; a floating pin has no value
	function logic [1:0] exp_dbg(input logic [3:0] c);
		logic [9:0] s;
		s = {src, 4'h8};
		return (c >= 4'h2 && c <= 4'h9) ? {1'b1, s[c]} : 2'b00;
	endfunction : exp_dbg
	task wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	// ==========================================================
	// Main sequence: reset values, decode, then every selector code with random fields
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		xfer(1'b0, 1'b1, 8'h44, 8'h00, 8'h00, 1'b1);
		xfer(1'b0, 1'b1, 8'h47, 8'h00, 8'h00, 1'b1);
		xfer(1'b1, 1'b0, 8'h48, 8'hff, 8'h00, 1'b0);
		xfer(1'b0, 1'b1, 8'h43, 8'h00, 8'h00, 1'b0);
		$display("reset and decode test done");
		for (int i = 0; i < 16; i++) begin
			en = 8'($random(seed));
			val = 8'($random(seed));
			sel = {4'($random(seed)), i[3:0]};
			@(posedge clk);
			boundary_scan_active <= i[2];
			clock_pin_source_code <= {2'b00, i[1:0]};
			clock_function_out <= 1'($random(seed));
			src <= 6'($random(seed));
			ext_val <= 8'($random(seed));
			// Back to back writes, the last one aimed at the read-only level register
			op(1'b1, 1'b0, 8'h44, en);
			op(1'b1, 1'b0, 8'h45, val);
			op(1'b1, 1'b0, 8'h47, sel);
			op(1'b1, 1'b0, 8'h46, 8'($random(seed)));
			op(1'b0, 1'b0, 8'h00, 8'h00);
			repeat (8) @(posedge clk);
			#1;
			eo = en;
			ev = val;
			if (boundary_scan_active) eo[3:0] = 4'h0;
			if (!en[6] && clock_pin_source_code != 4'h0) begin
				eo[6] = 1'b1;
				ev[6] = clock_function_out;
			end
			chk(pin_oe, eo);
			chk(pin_out & eo, ev & eo);
			chk({7'h00, clock_pin_gpio}, {7'h00, en[6] || clock_pin_source_code == 4'h0});
			chk({7'h00, fast_edge_select}, {7'h00, sel[7]});
			chk({6'h00, debug_output_pin_oe, debug_output_pin & debug_output_pin_oe},
				{6'h00, exp_dbg(i[3:0])});
			xfer(1'b0, 1'b1, 8'h44, 8'h00, en, 1'b1);
			xfer(1'b0, 1'b1, 8'h45, 8'h00, val, 1'b1);
			xfer(1'b0, 1'b1, 8'h47, 8'h00, sel & 8'h8f, 1'b1);
			xfer(1'b0, 1'b1, 8'h46, 8'h00, (ev & eo) | (ext_val & ~eo), 1'b1);
			$display("code %0d test done", i);
		end
		wrap_up();
	end

	// Watchdog: the run needs well under 1000 cycles
	initial begin
		#100us;
		n_mismatch++;
		wrap_up();
	end
endmodule : tb_top
